// [rtl/flash_host_pkg.sv]
// constants, types and opcode decode for the serial flash host controller
package flash_host_pkg;

    // ----------------------------------------
    // apb register map
    // ----------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_ADDR = 8'h04;
    localparam logic [7:0] OFF_TX = 8'h08;
    localparam logic [7:0] OFF_RX = 8'h0c;
    localparam logic [7:0] OFF_STAT = 8'h10;
    localparam int CTRL_START = 8;
    localparam int CTRL_ID_ADDR = 9;
    localparam int CTRL_WP_HIGH = 10;
    localparam int CTRL_LEN_LSB = 16;
    localparam int STAT_BUSY = 0;
    localparam int STAT_TX_FULL = 1;
    localparam int STAT_RX_FULL = 2;

    // ----------------------------------------
    // flash opcodes and status bit positions
    // ----------------------------------------
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FAST = 8'h0b;
    localparam logic [7:0] OP_DREAD = 8'h3b;
    localparam logic [7:0] OP_DIO = 8'hbb;
    localparam logic [7:0] OP_SSE = 8'h20;
    localparam logic [7:0] OP_SSE_ALT = 8'hd7;
    localparam logic [7:0] OP_SE = 8'hd8;
    localparam logic [7:0] OP_CE = 8'h60;
    localparam logic [7:0] OP_CE_ALT = 8'hc7;
    localparam logic [7:0] OP_PP = 8'h02;
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_PDOWN = 8'hb9;
    localparam logic [7:0] OP_RDSR = 8'h05;
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_JID = 8'h9f;
    localparam logic [7:0] OP_ID = 8'hab;
    localparam int SR_BUSY = 0;
    localparam int SR_WEL = 1;
    localparam int SR_PROT_LSB = 2;
    localparam int SR_SIDE = 5;
    localparam int SR_LOCK = 7;

    // ----------------------------------------
    // clock counts of a frame
    // ----------------------------------------
    localparam logic [5:0] CMD_CLKS = 6'h08;
    localparam logic [5:0] ADDR_CLKS_SINGLE = 6'h18;
    localparam logic [5:0] ADDR_CLKS_DUAL = 6'h0c;
    localparam logic [5:0] DUMMY_SINGLE = 6'h08;
    localparam logic [5:0] DUMMY_DUAL = 6'h04;
    localparam logic [5:0] DUMMY_HOST_DRIVE = 6'h02;
    localparam logic [2:0] LAST_BIT_SINGLE = 3'h7;
    localparam logic [2:0] LAST_BIT_DUAL = 3'h3;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SHIFT = 4'b0010,
        ST_WAIT = 4'b0100,
        ST_END = 4'b1000
    } st_t;

    typedef struct packed {
        logic has_addr;
        logic addr_dual;
        logic [5:0] dummy;
        logic data_rx;
        logic data_tx;
        logic data_dual;
    } fmt_t;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic io0_o;
        logic io0_oe_n;
        logic io1_o;
        logic io1_oe_n;
        logic wp_n;
    } pins_t;

    localparam pins_t PINS_IDLE = '{cs_n: 1'b1, sck: 1'b0, io0_o: 1'b0, io0_oe_n: 1'b1,
                                    io1_o: 1'b0, io1_oe_n: 1'b1, wp_n: 1'b0};

    // frame shape of each opcode; unknown opcodes go out alone
    function automatic fmt_t decode(input logic [7:0] opc, input logic id_addr);
        fmt_t f;
        f = '0;
        case (opc)
            OP_READ: begin
                f.has_addr = 1'b1;
                f.data_rx = 1'b1;
            end
            OP_FAST: begin // see RULE2
                f.has_addr = 1'b1;
                f.dummy = DUMMY_SINGLE;
                f.data_rx = 1'b1;
            end
            OP_DREAD: begin // see RULE3
                f.has_addr = 1'b1;
                f.dummy = DUMMY_SINGLE;
                f.data_rx = 1'b1;
                f.data_dual = 1'b1;
            end
            OP_DIO: begin
                f.has_addr = 1'b1;
                f.addr_dual = 1'b1;
                f.dummy = DUMMY_DUAL;
                f.data_rx = 1'b1;
                f.data_dual = 1'b1;
            end
            OP_SSE, OP_SSE_ALT, OP_SE: f.has_addr = 1'b1; // see RULE11
            OP_PP: begin
                f.has_addr = 1'b1;
                f.data_tx = 1'b1;
            end
            OP_WRSR: f.data_tx = 1'b1;
            OP_RDSR, OP_JID: f.data_rx = 1'b1;
            OP_ID: begin
                f.has_addr = id_addr; // see RULE14
                f.data_rx = id_addr;
            end
            default: f = '0;
        endcase
        return f;
    endfunction

endpackage

// [rtl/flash_host.sv]
// apb-controlled host engine that drives a serial flash over its spi pins
// Function
// RULE1 - read: opcode 03h, three address bytes, data on the single output line
// RULE2 - fast read: 0Bh, three address bytes, eight dummy bits, single-line data
// RULE3 - dual output read: 3Bh, address and dummy single line, data on both lines
// RULE4 - dual data: bits 7,5,3,1 on io line 0, bits 6,4,2,0 on io line 1
// RULE5 - dual-io read: BBh, address two bits per clock, four dummy clocks, dual data
// RULE6 - dual-io address: odd bits on io line 1, even bits on io line 0
// RULE7 - last two dual-io dummy clocks: both lines released by host and device
// RULE8 - continued clocks read successive bytes, wrapping 7FFFFh to 00000h
// RULE9 - raising chip select ends any read; output floats while deselected
// RULE10 - address bits A23 to A19 are ignored by the device
// RULE11 - erase opcodes 20h/D7h, D8h with address; 60h/C7h alone
// RULE12 - page program: 02h, three address bytes, then program data bytes
// RULE13 - single-byte opcodes 06h 04h B9h 05h 9Fh; status write 01h plus one byte
// RULE14 - ABh with three don't-care bytes returns id; ABh alone leaves power-down
// RULE15 - eight 64 KB sectors of sixteen 4 KB small sectors, numbered 0 to 127
// RULE16 - status register is eight bits with busy, latch, level, side, lock
// RULE17 - status lock set disables status register writes
// RULE18 - side select places the protected area at top or bottom
// RULE19 - busy, latch and reserved read 0 after power-on; others nonvolatile
// RULE20 - unknown opcode: device ignores clocks, outputs float until deselect
// RULE21 - clock level at select picks mode 0 (low) or mode 3 (high)
// RULE22 - busy reads 1 during program, erase or status write
// RULE23 - status read repeats bit 7 to bit 0 while clocks continue
// RULE24 - write-enable latch clears at power-on and after each completed write
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/10ps
module flash_host #(
    parameter int HALF_CYC = 4,
    parameter int LEN_W = 16
) (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // flash pins
    output flash_host_pkg::pins_t flash_pins,
    input wire logic io0_i,
    input wire logic io1_i
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    localparam logic [7:0] HALF_M1 = 8'(HALF_CYC - 1);

    typedef struct packed {
        flash_host_pkg::st_t st;
        logic [7:0] div;
        logic [5:0] clk;
        logic data;
        logic [2:0] bitc;
        logic [LEN_W-1:0] left;
        logic [31:0] sh;
        logic [7:0] rxsh;
        flash_host_pkg::fmt_t fmt;
        flash_host_pkg::pins_t pins;
        logic [7:0] opcode;
        logic id_addr;
        logic wp_high;
        logic [LEN_W-1:0] len;
        logic [23:0] addr;
        logic [7:0] tx;
        logic tx_full;
        logic [7:0] rx;
        logic rx_full;
        logic [1:0] s1;
        logic [1:0] s2;
        logic [31:0] prdata;
        logic slverr;
    } state_t;

    state_t q;
    state_t n;

    function automatic logic [5:0] addr_end(input flash_host_pkg::fmt_t f);
        logic [5:0] a;
        a = flash_host_pkg::CMD_CLKS;
        if (f.has_addr) begin
            a = a + (f.addr_dual ? flash_host_pkg::ADDR_CLKS_DUAL : flash_host_pkg::ADDR_CLKS_SINGLE);
        end
        return a;
    endfunction

    // {io1_o, io1_oe_n, io0_o, io0_oe_n} for header clock c or a data bit
    function automatic logic [3:0] drive(input logic [5:0] c, input logic dat, input flash_host_pkg::fmt_t f,
                                         input logic [31:0] s);
        logic [3:0] d;
        logic [5:0] ae;
        ae = addr_end(f);
        d = {1'b0, 1'b1, 1'b0, 1'b1};
        if (dat) begin
            if (f.data_tx) begin
                d = {1'b0, 1'b1, s[31], 1'b0};
            end
        end else if (c < flash_host_pkg::CMD_CLKS || (c < ae && !f.addr_dual)) begin
            d = {1'b0, 1'b1, s[31], 1'b0};
        end else if (c < ae) begin
            d = {s[31], 1'b0, s[30], 1'b0}; // see RULE6
        end else if (f.addr_dual) begin
            // host keeps the first dual dummy clocks, then lets go
            if (c - ae < flash_host_pkg::DUMMY_HOST_DRIVE) begin
                d = {1'b0, 1'b0, 1'b0, 1'b0};
            end else begin
                d = {1'b0, 1'b1, 1'b0, 1'b1}; // see RULE7
            end
        end else begin
            d = {1'b0, 1'b1, 1'b0, 1'b0};
        end
        return d;
    endfunction

    logic wr_acc;
    logic rd_acc;
    logic hit;
    logic go_ok;
    logic [5:0] hdr_last;
    logic [2:0] last_bit;
    logic [7:0] rx_next;
    logic [3:0] dv;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        n = q;
        n.s1 = {io1_i, io0_i};
        n.s2 = q.s1;
        wr_acc = psel && penable && pwrite;
        rd_acc = psel && penable && !pwrite;
        hit = paddr == flash_host_pkg::OFF_CTRL || paddr == flash_host_pkg::OFF_ADDR ||
              paddr == flash_host_pkg::OFF_TX || paddr == flash_host_pkg::OFF_RX ||
              paddr == flash_host_pkg::OFF_STAT;
        hdr_last = addr_end(q.fmt) + q.fmt.dummy - 6'h01;
        last_bit = q.fmt.data_dual ? flash_host_pkg::LAST_BIT_DUAL : flash_host_pkg::LAST_BIT_SINGLE;
        // odd bits arrive on io line 0 first in dual mode
        rx_next = q.fmt.data_dual ? {q.rxsh[5:0], q.s2[0], q.s2[1]} : {q.rxsh[6:0], q.s2[1]}; // see RULE4
        go_ok = q.fmt.data_rx ? !q.rx_full : (q.fmt.data_tx ? q.tx_full : 1'b1);
        dv = '0;

        // read data is latched in the setup cycle so prdata comes from a flop
        if (psel && !penable) begin
            n.slverr = !hit;
            case (paddr)
                flash_host_pkg::OFF_CTRL: begin
                    n.prdata = '0;
                    n.prdata[7:0] = q.opcode;
                    n.prdata[flash_host_pkg::CTRL_ID_ADDR] = q.id_addr;
                    n.prdata[flash_host_pkg::CTRL_WP_HIGH] = q.wp_high;
                    n.prdata[flash_host_pkg::CTRL_LEN_LSB +: LEN_W] = q.len;
                end
                flash_host_pkg::OFF_ADDR: n.prdata = {8'h00, q.addr};
                flash_host_pkg::OFF_TX: n.prdata = {24'h000000, q.tx};
                flash_host_pkg::OFF_RX: n.prdata = {24'h000000, q.rx};
                flash_host_pkg::OFF_STAT: begin
                    n.prdata = '0;
                    n.prdata[flash_host_pkg::STAT_BUSY] = q.st != flash_host_pkg::ST_IDLE;
                    n.prdata[flash_host_pkg::STAT_TX_FULL] = q.tx_full;
                    n.prdata[flash_host_pkg::STAT_RX_FULL] = q.rx_full;
                end
                default: n.prdata = '0;
            endcase
        end
        if (wr_acc) begin
            case (paddr)
                flash_host_pkg::OFF_CTRL: begin
                    n.opcode = pwdata[7:0];
                    n.id_addr = pwdata[flash_host_pkg::CTRL_ID_ADDR];
                    n.wp_high = pwdata[flash_host_pkg::CTRL_WP_HIGH];
                    n.len = pwdata[flash_host_pkg::CTRL_LEN_LSB +: LEN_W];
                end
                flash_host_pkg::OFF_ADDR: n.addr = pwdata[23:0];
                flash_host_pkg::OFF_TX: begin
                    n.tx = pwdata[7:0];
                    n.tx_full = 1'b1;
                end
                default: ;
            endcase
        end
        if (rd_acc && paddr == flash_host_pkg::OFF_RX) begin
            n.rx_full = 1'b0;
        end
        n.pins.wp_n = q.wp_high;

        // engine runs after the bus so its sets win over a same-cycle clear
        case (q.st)
            flash_host_pkg::ST_IDLE: begin
                // start takes opcode, id bit and length from this same write and the address already in place, a start is ignored while busy
                if (wr_acc && paddr == flash_host_pkg::OFF_CTRL && pwdata[flash_host_pkg::CTRL_START]) begin
                    n.fmt = flash_host_pkg::decode(pwdata[7:0], pwdata[flash_host_pkg::CTRL_ID_ADDR]); // see RULE13
                    n.sh = {pwdata[7:0], q.addr};
                    n.left = pwdata[flash_host_pkg::CTRL_LEN_LSB +: LEN_W];
                    n.clk = '0;
                    n.data = 1'b0;
                    n.bitc = '0;
                    n.div = HALF_M1;
                    n.pins.sck = 1'b0; // see RULE21
                    n.pins.cs_n = 1'b0;
                    dv = drive(6'h00, 1'b0, n.fmt, n.sh);
                    {n.pins.io1_o, n.pins.io1_oe_n, n.pins.io0_o, n.pins.io0_oe_n} = dv;
                    n.st = flash_host_pkg::ST_SHIFT;
                end
            end
            flash_host_pkg::ST_SHIFT: begin
                if (q.div != 8'h00) begin
                    n.div = q.div - 8'h01;
                end else if (!q.pins.sck) begin
                    // rising edge: take a read bit
                    n.div = HALF_M1;
                    n.pins.sck = 1'b1;
                    if (q.data && q.fmt.data_rx) begin
                        n.rxsh = rx_next;
                        if (q.bitc == last_bit) begin
                            n.rx = rx_next;
                            n.rx_full = 1'b1;
                        end
                    end
                end else begin
                    // falling edge: move on to the next bit
                    n.div = HALF_M1;
                    n.pins.sck = 1'b0;
                    if (!q.data) begin
                        if (q.clk == hdr_last) begin
                            // the device may drive both lines from this edge on, so let go now
                            if (q.fmt.data_rx) begin
                                n.pins.io0_oe_n = 1'b1; // see RULE3
                                n.pins.io1_oe_n = 1'b1;
                            end
                            // frames without a data phase ignore len and end after the header
                            n.st = (q.left == '0 || !(q.fmt.data_rx || q.fmt.data_tx)) ?
                                flash_host_pkg::ST_END : flash_host_pkg::ST_WAIT;
                        end else begin
                            n.clk = q.clk + 6'h01;
                            if (q.fmt.addr_dual && q.clk >= flash_host_pkg::CMD_CLKS) begin
                                n.sh = {q.sh[29:0], 2'b00}; // see RULE5
                            end else begin
                                n.sh = {q.sh[30:0], 1'b0}; // see RULE1
                            end
                            dv = drive(n.clk, 1'b0, q.fmt, n.sh);
                            {n.pins.io1_o, n.pins.io1_oe_n, n.pins.io0_o, n.pins.io0_oe_n} = dv;
                        end
                    end else if (q.bitc == last_bit) begin
                        // the device steps its own address, so long reads need no re-issue
                        n.left = q.left - 1'b1; // see RULE8
                        n.st = q.left == 1 ? flash_host_pkg::ST_END : flash_host_pkg::ST_WAIT;
                    end else begin
                        n.bitc = q.bitc + 3'h1;
                        n.sh = {q.sh[30:0], 1'b0};
                        dv = drive(q.clk, 1'b1, q.fmt, n.sh);
                        {n.pins.io1_o, n.pins.io1_oe_n, n.pins.io0_o, n.pins.io0_oe_n} = dv;
                    end
                end
                if (n.st == flash_host_pkg::ST_END) begin
                    n.pins.cs_n = 1'b1; // see RULE9
                    n.pins.io0_oe_n = 1'b1;
                    n.pins.io1_oe_n = 1'b1;
                    n.div = HALF_M1;
                end
            end
            flash_host_pkg::ST_WAIT: begin
                // sck parks low until software has room for, or supplies, the next byte
                if (go_ok) begin
                    n.data = 1'b1;
                    n.bitc = '0;
                    n.div = HALF_M1;
                    if (q.fmt.data_tx) begin
                        n.sh[31:24] = q.tx; // see RULE12
                        n.tx_full = wr_acc && paddr == flash_host_pkg::OFF_TX;
                    end
                    dv = drive(q.clk, 1'b1, q.fmt, n.sh);
                    {n.pins.io1_o, n.pins.io1_oe_n, n.pins.io0_o, n.pins.io0_oe_n} = dv;
                    n.st = flash_host_pkg::ST_SHIFT;
                end
            end
            flash_host_pkg::ST_END: begin
                // deselect time before the next frame may start
                if (q.div != 8'h00) begin
                    n.div = q.div - 8'h01;
                end else begin
                    n.st = flash_host_pkg::ST_IDLE;
                end
            end
            default: n.st = flash_host_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.st <= flash_host_pkg::ST_IDLE;
            q.pins <= flash_host_pkg::PINS_IDLE;
        end else begin
            q <= n;
        end
    end

    assign prdata = q.prdata;
    assign pslverr = q.slverr;
    assign pready = 1'b1;
    assign flash_pins = q.pins;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_READ_HDR: assert property ((q.st == flash_host_pkg::ST_WAIT && !q.data && q.opcode == flash_host_pkg::OP_READ)
        |-> q.clk == 6'h1f && !q.fmt.data_dual) else $error("read header not 32 clocks"); // see RULE1
    AST_FAST_HDR: assert property ((q.st == flash_host_pkg::ST_WAIT && !q.data && q.opcode == flash_host_pkg::OP_FAST)
        |-> q.clk == 6'h27) else $error("fast read header not 40 clocks"); // see RULE2
    AST_DREAD_HDR: assert property ((q.st == flash_host_pkg::ST_WAIT && !q.data && q.opcode == flash_host_pkg::OP_DREAD)
        |-> q.clk == 6'h27 && q.fmt.data_dual && !q.fmt.addr_dual) else $error("dual read format wrong"); // see RULE3
    AST_DIO_HDR: assert property ((q.st == flash_host_pkg::ST_WAIT && !q.data && q.opcode == flash_host_pkg::OP_DIO)
        |-> q.clk == 6'h17) else $error("dual io header not 24 clocks"); // see RULE5
    AST_DIO_ADDR: assert property ((q.st == flash_host_pkg::ST_SHIFT && q.fmt.addr_dual && !q.data &&
        q.clk >= 6'h08 && q.clk < 6'h14) |-> !q.pins.io0_oe_n && !q.pins.io1_oe_n && q.pins.io1_o == q.sh[31])
        else $error("dual io address not on both lines"); // see RULE6
    AST_DIO_FLOAT: assert property ((q.st == flash_host_pkg::ST_SHIFT && q.fmt.addr_dual && !q.data &&
        q.clk >= 6'h16) |-> q.pins.io0_oe_n && q.pins.io1_oe_n) else $error("host drives in turnaround"); // see RULE7
    AST_END_FRAME: assert property ($rose(q.pins.cs_n) |-> !q.pins.sck && q.pins.io0_oe_n && q.pins.io1_oe_n
        ##1 q.pins.cs_n[*3]) else $error("frame end not clean"); // see RULE9
    AST_MODE0: assert property ($fell(q.pins.cs_n) |-> !q.pins.sck ##1 !q.pins.sck)
        else $error("sck not low at select"); // see RULE21
    AST_ERASE_FMT: assert property ((q.st == flash_host_pkg::ST_SHIFT && (q.opcode == flash_host_pkg::OP_SSE ||
        q.opcode == flash_host_pkg::OP_SSE_ALT || q.opcode == flash_host_pkg::OP_SE)) |-> q.fmt.has_addr &&
        !q.fmt.data_tx && !q.fmt.data_rx) else $error("erase format wrong"); // see RULE11
    AST_PP_FMT: assert property ((q.st == flash_host_pkg::ST_SHIFT && q.opcode == flash_host_pkg::OP_PP)
        |-> q.fmt.has_addr && q.fmt.data_tx) else $error("program format wrong"); // see RULE12
    AST_WRSR_FMT: assert property ((q.st == flash_host_pkg::ST_SHIFT && q.opcode == flash_host_pkg::OP_WRSR)
        |-> q.fmt.data_tx && !q.fmt.has_addr) else $error("status write format wrong"); // see RULE13
    AST_ID_FMT: assert property ((q.st == flash_host_pkg::ST_SHIFT && q.opcode == flash_host_pkg::OP_ID)
        |-> q.fmt.has_addr == q.id_addr) else $error("id form wrong"); // see RULE14

    COV_DUAL_DATA: cover property (q.st == flash_host_pkg::ST_WAIT && q.data && q.fmt.addr_dual);
    COV_TX_STALL: cover property (q.st == flash_host_pkg::ST_WAIT && q.fmt.data_tx && !q.tx_full);
    COV_RX_STALL: cover property (q.st == flash_host_pkg::ST_WAIT && q.rx_full);

endmodule

// [sim/flash_dev_model.sv]
// behavioural serial flash: reads and status read over a fixed data pattern
`timescale 1ns/10ps
module flash_dev_model #(
    parameter logic [7:0] SR_INIT = 8'h9c
) (
    // host pins
    input wire flash_host_pkg::pins_t pins,
    // resolved lines
    output logic io0,
    output logic io1
);
    logic [7:0] op;
    logic [7:0] b;
    logic [23:0] a;
    int n;
    int h;
    int k;
    logic d0, d1, e0, e1, fz;
    logic [15:0] pb;
    logic mode3;
    function automatic logic [7:0] mem(input logic [18:0] x);
        return x[7:0] ^ x[15:8] ^ {5'h00, x[18:16]};
    endfunction
    // released lines toggle so a stale level never passes for data
    assign io0 = !pins.io0_oe_n ? pins.io0_o : e0 ? d0 : fz;
    assign io1 = !pins.io1_oe_n ? pins.io1_o : e1 ? d1 : ~fz;
    initial begin
        {n, e0, e1, fz, op, a, pb, mode3} = '0;
    end
    always @(negedge pins.cs_n) begin
        n = 0;
        mode3 = pins.sck;
    end
    always @(posedge pins.sck) begin
        fz = ~fz;
        if (!pins.cs_n) begin
            if (n < 8) op = {op[6:0], io0};
            else if (op == 8'hbb && n < 20) a = {a[21:0], io1, io0};
            else if (op != 8'h05 && op != 8'hbb && n < 32) a = {a[22:0], io0};
            else if (op == 8'h02) pb = {pb[14:0], io0};
            n = n + 1;
        end
    end
    // output changes on falling sck; deselect floats both lines
    always @(negedge pins.sck or posedge pins.cs_n) begin
        h = op == 8'h03 ? 32 : op == 8'hbb ? 24 : op == 8'h05 ? 8 : 40;
        k = n - h;
        e0 = 0;
        e1 = 0;
        if (!pins.cs_n && n >= h && op inside {8'h03, 8'h0b, 8'h3b, 8'hbb, 8'h05}) begin
            if (op inside {8'h3b, 8'hbb}) begin
                b = mem(a[18:0] + 19'(k / 4));
                d0 = b[7 - 2 * (k % 4)];
                d1 = b[6 - 2 * (k % 4)];
                e0 = 1;
                e1 = 1;
            end else begin
                b = op == 8'h05 ? SR_INIT : mem(a[18:0] + 19'(k / 8));
                d1 = b[7 - k % 8];
                e1 = 1;
            end
        end
    end
endmodule

// [sim/flash_host_tb.sv]
// self-checking bench: apb-driven reads against the flash model
`timescale 1ns/10ps
module flash_host_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, io0, io1, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, lf;
    flash_host_pkg::pins_t pins;
    int fail_count, checks, cyc;
    logic [7:0] ops [5] = '{8'h03, 8'h0b, 8'h3b, 8'hbb, 8'h05};
    flash_host uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flash_pins(pins), .io0_i(io0), .io1_i(io1));
    flash_dev_model dev (.pins(pins), .io0(io0), .io1(io1));
    initial begin
        pclk = 0;
        forever #4 pclk = ~pclk;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] exp_byte(input logic [7:0] op, input logic [23:0] a, input int i);
        logic [18:0] x;
        x = a[18:0] + 19'(i); // wraps at the top of the 19-bit space
        return op == 8'h05 ? 8'h9c : x[7:0] ^ x[15:8] ^ {5'h00, x[18:16]};
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic run(input logic [7:0] op, input logic [23:0] ad, input int len);
        apb(1, flash_host_pkg::OFF_ADDR, {8'h00, ad});
        apb(1, flash_host_pkg::OFF_CTRL, {16'(len), 8'h01, op});
        for (int i = 0; i < len; i++) begin
            do apb(0, flash_host_pkg::OFF_STAT, 0); while (rd[2] !== 1'b1);
            apb(0, flash_host_pkg::OFF_RX, 0);
            cmp(32'(rd[7:0]), 32'(exp_byte(op, ad, i)), "rx byte");
        end
        do apb(0, flash_host_pkg::OFF_STAT, 0); while (rd[0] !== 1'b0);
        cmp(32'({pins.cs_n, pins.io0_oe_n, pins.io1_oe_n, pins.wp_n}), 32'he, "deselect");
        $display("test op %h addr %h done", op, ad);
    endtask
    // write-type frames: the model counts clocks and keeps address and program bytes
    task automatic wr(input logic [7:0] op, input logic [23:0] ad, input int len, input int clks);
        logic [15:0] pd;
        lf = lfsr(lf);
        pd = lf[15:0];
        apb(1, flash_host_pkg::OFF_TX, {24'h000000, pd[15:8]});
        apb(1, flash_host_pkg::OFF_ADDR, {8'h00, ad});
        apb(1, flash_host_pkg::OFF_CTRL, {16'(len), 8'h05, op});
        if (len > 1) begin
            do apb(0, flash_host_pkg::OFF_STAT, 0); while (rd[1] !== 1'b0);
            apb(1, flash_host_pkg::OFF_TX, {24'h000000, pd[7:0]});
        end
        do apb(0, flash_host_pkg::OFF_STAT, 0); while (rd[0] !== 1'b0);
        cmp(32'(dev.n), 32'(clks), "frame clocks");
        if (clks > 8) cmp(32'(dev.a), 32'(ad), "frame address");
        if (len > 1) cmp(32'(dev.pb), 32'(pd), "program bytes");
        cmp(32'({dev.mode3, pins.wp_n}), 32'h1, "mode and wp");
        $display("test op %h addr %h done", op, ad);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 40000) begin
            fail_count++;
            $display("[FAIL] %0t timeout", $time);
            end_of_test();
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, fail_count, checks, cyc} = '0;
        lf = 32'hea76;
        repeat (10) @(posedge pclk);
        cmp(32'(pins), 32'(flash_host_pkg::PINS_IDLE), "reset pins");
        presetn <= 1;
        apb(0, 8'h40, 0);
        cmp(32'(err), 32'h1, "unmapped");
        wr(8'h20, lf[23:0], 0, 32);
        wr(8'h02, 24'h0a5f00, 2, 48);
        wr(8'h77, 24'h000000, 1, 8);
        // first pass ends at the top and wraps; upper address bits set
        for (int t = 0; t < 10; t++) begin
            lf = lfsr(lf);
            run(ops[t % 5], t < 5 ? 24'hfffffe : lf[23:0], t < 5 ? 3 : 1 + int'(lf[25:24]));
        end
        end_of_test();
    end
endmodule
